// ==== cpu_working_register_set_map.svh ====
// Register selects, field positions and widths of the working register set
`ifndef CPU_WORKING_REGISTER_SET_MAP_SVH
`define CPU_WORKING_REGISTER_SET_MAP_SVH

`define SEL_FIRST_ACC      4'h0
`define SEL_SECOND_ACC     4'h1
`define SEL_PROG_COUNTER   4'h2
`define SEL_CARRY_LINK     4'h3
`define SEL_OVERFLOW       4'h4
`define SEL_LAST_INT_CODE  4'h5
`define SEL_VIOLATION      4'h6
`define SEL_PARITY_LO      4'h7
`define SEL_PARITY_HI      4'h8
`define SEL_INT_ENABLE     4'h9
`define SEL_INDEX_FIRST    4'ha
`define SEL_INDEX_SECOND   4'hb
`define SEL_WORKING_MAP    4'hc
`define SEL_INT_MAP_COPY   4'hd

`define ADDR_FIRST_ACC     15'h0000
`define ADDR_SECOND_ACC    15'h0001

`define ACC_MSB            15
`define INT_ENABLE_RESET   1'b0

`endif

// ==== cpu_working_register_set_pkg.sv ====
// Types shared by the working register set modules
package cpu_working_register_set_pkg;

  typedef logic [15:0] word_t;
  typedef logic [14:0] addr_t;

  typedef enum logic [1:0]
  {
    FLAG_HOLD   = 2'b00,
    FLAG_SET    = 2'b01,
    FLAG_CLEAR  = 2'b10,
    FLAG_INVERT = 2'b11
  } flag_op_e;

  typedef enum logic [1:0]
  {
    ROT_NONE  = 2'b00,
    ROT_LEFT  = 2'b01,
    ROT_RIGHT = 2'b10
  } rot_op_e;

endpackage

// ==== flag_path_if.sv ====
// Bundle carrying flag controls and results between the register set and its flag unit
`timescale 1ns/1ps
`default_nettype none

interface flag_path_if;
  import cpu_working_register_set_pkg::*;

  flag_op_e carry_op;
  flag_op_e ovf_op;
  logic     carry_event;
  logic     ovf_event;
  logic     rotate_link_load;
  logic     rotate_link_value;
  logic     panel_carry_wr;
  logic     panel_ovf_wr;
  logic     panel_value;
  logic     carry_link_flag;
  logic     overflow_flag;

  modport owner
  (
    output carry_op, ovf_op, carry_event, ovf_event, rotate_link_load,
           rotate_link_value, panel_carry_wr, panel_ovf_wr, panel_value,
    input  carry_link_flag, overflow_flag
  );

  modport unit
  (
    input  carry_op, ovf_op, carry_event, ovf_event, rotate_link_load,
           rotate_link_value, panel_carry_wr, panel_ovf_wr, panel_value,
    output carry_link_flag, overflow_flag
  );
endinterface

`default_nettype wire

// ==== status_flag_unit.sv ====
// Extend and overflow flag unit
`timescale 1ns/1ps
`default_nettype none

module status_flag_unit
(
  input  wire logic  clk,
  input  wire logic  rst,
  input  wire logic  clk_en,
  flag_path_if.unit  fp
);
  import cpu_working_register_set_pkg::*;

  // ---------------------------------------------------------------
  // Extend flag
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
      fp.carry_link_flag <= 1'b0;
    else if (clk_en)
    begin
      if (fp.panel_carry_wr)
        fp.carry_link_flag <= fp.panel_value;
      else if (fp.rotate_link_load)
        fp.carry_link_flag <= fp.rotate_link_value;
      else if (fp.carry_op == FLAG_SET)
        fp.carry_link_flag <= 1'b1;
      else if (fp.carry_op == FLAG_CLEAR)
        fp.carry_link_flag <= fp.carry_event;
      else if (fp.carry_op == FLAG_INVERT)
        fp.carry_link_flag <= ~fp.carry_link_flag | fp.carry_event;
      else if (fp.carry_event)
        fp.carry_link_flag <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Overflow flag
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
      fp.overflow_flag <= 1'b0;
    else if (clk_en)
    begin
      if (fp.panel_ovf_wr)
        fp.overflow_flag <= fp.panel_value;
      else if (fp.ovf_op == FLAG_SET)
        fp.overflow_flag <= 1'b1;
      else if (fp.ovf_op == FLAG_CLEAR)
        fp.overflow_flag <= fp.ovf_event;
      else if (fp.ovf_event)
        fp.overflow_flag <= 1'b1;
    end
  end
endmodule // status_flag_unit

`default_nettype wire

// ==== cpu_working_register_set.sv ====
// Processor working register set with datapath and panel access
`timescale 1ns/1ps
`default_nettype none
`include "cpu_working_register_set_map.svh"

module cpu_working_register_set
(
  input  wire logic                                  clk,
  input  wire logic                                  rst,
  input  wire logic                                  clk_en,
  input  wire logic                                  acc_first_wr,
  input  wire logic                                  acc_second_wr,
  input  wire cpu_working_register_set_pkg::word_t   acc_result,
  input  wire logic                                  alu_carry_out,
  input  wire logic                                  alu_overflow,
  input  wire logic                                  alu_flag_update,
  input  wire cpu_working_register_set_pkg::flag_op_e carry_op,
  input  wire cpu_working_register_set_pkg::flag_op_e ovf_op,
  input  wire cpu_working_register_set_pkg::rot_op_e rot_op,
  input  wire logic                                  rot_use_link,
  input  wire logic                                  rot_second,
  input  wire logic                                  mem_ref_valid,
  input  wire logic                                  mem_ref_write,
  input  wire cpu_working_register_set_pkg::addr_t   mem_ref_addr,
  input  wire cpu_working_register_set_pkg::word_t   mem_ref_wdata,
  input  wire logic                                  pc_load,
  input  wire cpu_working_register_set_pkg::addr_t   pc_value,
  input  wire logic                                  pc_step,
  input  wire logic                                  int_serviced,
  input  wire logic [5:0]                            int_select_code,
  input  wire logic                                  int_enable_set,
  input  wire logic                                  int_enable_clear,
  input  wire logic                                  violation_detect,
  input  wire cpu_working_register_set_pkg::addr_t   fetch_addr,
  input  wire logic                                  parity_error,
  input  wire logic [23:0]                           parity_phys_addr,
  input  wire logic                                  index_first_wr,
  input  wire logic                                  index_second_wr,
  input  wire cpu_working_register_set_pkg::word_t   index_wdata,
  input  wire logic                                  map_word_wr,
  input  wire cpu_working_register_set_pkg::word_t   map_word_wdata,
  input  wire logic                                  store_interrupt_map_instr,
  input  wire logic                                  panel_rd,
  input  wire logic                                  panel_wr,
  input  wire logic [3:0]                            panel_sel,
  input  wire cpu_working_register_set_pkg::word_t   panel_wdata,
  output var  cpu_working_register_set_pkg::word_t   first_accumulator,
  output var  cpu_working_register_set_pkg::word_t   second_accumulator,
  output var  cpu_working_register_set_pkg::addr_t   program_counter,
  output var  logic                                  carry_link_flag,
  output var  logic                                  overflow_flag,
  output var  logic [5:0]                            last_interrupt_code,
  output var  cpu_working_register_set_pkg::addr_t   violation_address,
  output var  logic [23:0]                           parity_fault_address,
  output var  logic                                  interrupt_system_enable,
  output var  cpu_working_register_set_pkg::word_t   index_reg_first,
  output var  cpu_working_register_set_pkg::word_t   index_reg_second,
  output var  cpu_working_register_set_pkg::word_t   working_map_word,
  output var  cpu_working_register_set_pkg::word_t   mem_ref_rdata,
  output var  logic                                  mem_ref_hit,
  output var  cpu_working_register_set_pkg::word_t   int_map_rdata,
  output var  cpu_working_register_set_pkg::word_t   panel_rdata,
  output var  logic                                  panel_rvalid
);
  import cpu_working_register_set_pkg::*;

  // ---------------------------------------------------------------
  // Internal state and decode
  // ---------------------------------------------------------------
  word_t       interrupt_map_copy;
  word_t       rot_src;
  word_t       next_rot_acc;
  logic        next_link;
  logic        link_load;
  logic        hit_first;
  logic        hit_second;
  logic        pwr;
  flag_path_if fp ();

  assign hit_first  = mem_ref_valid && (mem_ref_addr == `ADDR_FIRST_ACC);
  assign hit_second = mem_ref_valid && (mem_ref_addr == `ADDR_SECOND_ACC);
  assign pwr        = panel_wr;

  // ---------------------------------------------------------------
  // Rotation, optionally through the link
  // ---------------------------------------------------------------
  always_comb
  begin
    rot_src      = rot_second ? second_accumulator : first_accumulator;
    next_rot_acc = rot_src;
    next_link    = carry_link_flag;
    case (rot_op)
      ROT_LEFT:
      begin
        next_rot_acc = {rot_src[14:0], rot_use_link ? carry_link_flag : rot_src[15]};
        next_link    = rot_src[15];
        link_load    = rot_use_link;
      end
      ROT_RIGHT:
      begin
        next_rot_acc = {rot_use_link ? carry_link_flag : rot_src[0], rot_src[15:1]};
        next_link    = rot_src[0];
        link_load    = rot_use_link;
      end
      default: link_load = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Accumulators
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
      first_accumulator <= 16'h0000;
    else if (clk_en)
    begin
      if (pwr && panel_sel == `SEL_FIRST_ACC)
        first_accumulator <= panel_wdata;
      else if (hit_first && mem_ref_write)
        first_accumulator <= mem_ref_wdata;
      else if (acc_first_wr)
        first_accumulator <= acc_result;
      else if (rot_op != ROT_NONE && !rot_second)
        first_accumulator <= next_rot_acc;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      second_accumulator <= 16'h0000;
    else if (clk_en)
    begin
      if (pwr && panel_sel == `SEL_SECOND_ACC)
        second_accumulator <= panel_wdata;
      else if (hit_second && mem_ref_write)
        second_accumulator <= mem_ref_wdata;
      else if (acc_second_wr)
        second_accumulator <= acc_result;
      else if (rot_op != ROT_NONE && rot_second)
        second_accumulator <= next_rot_acc;
    end
  end

  // Memory reference read path for locations zero and one
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mem_ref_rdata <= 16'h0000;
      mem_ref_hit   <= 1'b0;
    end
    else if (clk_en)
    begin
      mem_ref_hit   <= hit_first || hit_second;
      mem_ref_rdata <= hit_second ? second_accumulator : first_accumulator;
    end
  end

  // ---------------------------------------------------------------
  // Program counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
      program_counter <= 15'h0000;
    else if (clk_en)
    begin
      if (pwr && panel_sel == `SEL_PROG_COUNTER)
        program_counter <= panel_wdata[14:0];
      else if (pc_load)
        program_counter <= pc_value;
      else if (pc_step)
        program_counter <= program_counter + 15'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Flag unit
  // ---------------------------------------------------------------
  assign fp.carry_op          = carry_op;
  assign fp.ovf_op            = ovf_op;
  assign fp.carry_event       = alu_flag_update && alu_carry_out;
  assign fp.ovf_event         = alu_flag_update && alu_overflow;
  assign fp.rotate_link_load  = link_load;
  assign fp.rotate_link_value = next_link;
  assign fp.panel_carry_wr    = pwr && panel_sel == `SEL_CARRY_LINK;
  assign fp.panel_ovf_wr      = pwr && panel_sel == `SEL_OVERFLOW;
  assign fp.panel_value       = panel_wdata[0];
  assign carry_link_flag      = fp.carry_link_flag;
  assign overflow_flag        = fp.overflow_flag;

  status_flag_unit u_flags
  (
    .clk    (clk),
    .rst    (rst),
    .clk_en (clk_en),
    .fp     (fp.unit)
  );

  // ---------------------------------------------------------------
  // Captured state
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      last_interrupt_code <= 6'h00;
      interrupt_map_copy  <= 16'h0000;
    end
    // code and map copy at interrupt
    else if (clk_en && int_serviced)
    begin
      last_interrupt_code <= int_select_code;
      interrupt_map_copy  <= working_map_word;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      violation_address <= 15'h0000;
    else if (clk_en && violation_detect)
      violation_address <= fetch_addr;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      parity_fault_address <= 24'h000000;
    else if (clk_en && parity_error)
      parity_fault_address <= parity_phys_addr;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      interrupt_system_enable <= `INT_ENABLE_RESET;
    else if (clk_en)
    begin
      if (pwr && panel_sel == `SEL_INT_ENABLE)
        interrupt_system_enable <= panel_wdata[0];
      else if (int_enable_set)
        interrupt_system_enable <= 1'b1;
      else if (int_enable_clear)
        interrupt_system_enable <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Index registers and mapping
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      index_reg_first  <= 16'h0000;
      index_reg_second <= 16'h0000;
    end
    else if (clk_en)
    begin
      if (pwr && panel_sel == `SEL_INDEX_FIRST)
        index_reg_first <= panel_wdata;
      else if (index_first_wr)
        index_reg_first <= index_wdata;
      if (pwr && panel_sel == `SEL_INDEX_SECOND)
        index_reg_second <= panel_wdata;
      else if (index_second_wr)
        index_reg_second <= index_wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      working_map_word <= 16'h0000;
    else if (clk_en)
    begin
      if (pwr && panel_sel == `SEL_WORKING_MAP)
        working_map_word <= panel_wdata;
      else if (map_word_wr)
        working_map_word <= map_word_wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      int_map_rdata <= 16'h0000;
    else if (clk_en && store_interrupt_map_instr)
      int_map_rdata <= interrupt_map_copy;
  end

  // ---------------------------------------------------------------
  // Operator panel read port
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      panel_rdata  <= 16'h0000;
      panel_rvalid <= 1'b0;
    end
    else if (clk_en)
    begin
      panel_rvalid <= panel_rd;
      if (panel_rd)
      begin
        case (panel_sel)
          `SEL_FIRST_ACC:     panel_rdata <= first_accumulator;
          `SEL_SECOND_ACC:    panel_rdata <= second_accumulator;
          `SEL_PROG_COUNTER:  panel_rdata <= {1'b0, program_counter};
          `SEL_CARRY_LINK:    panel_rdata <= {15'h0000, carry_link_flag};
          `SEL_OVERFLOW:      panel_rdata <= {15'h0000, overflow_flag};
          `SEL_LAST_INT_CODE: panel_rdata <= {10'h000, last_interrupt_code};
          `SEL_VIOLATION:     panel_rdata <= {1'b0, violation_address};
          `SEL_PARITY_LO:     panel_rdata <= parity_fault_address[15:0];
          `SEL_PARITY_HI:     panel_rdata <= {8'h00, parity_fault_address[23:16]};
          `SEL_INT_ENABLE:    panel_rdata <= {15'h0000, interrupt_system_enable};
          `SEL_INDEX_FIRST:   panel_rdata <= index_reg_first;
          `SEL_INDEX_SECOND:  panel_rdata <= index_reg_second;
          `SEL_WORKING_MAP:   panel_rdata <= working_map_word;
          default:            panel_rdata <= 16'h0000;
        endcase
      end
    end
  end
endmodule // cpu_working_register_set

`default_nettype wire

// ==== cpu_working_register_set_chk.sv ====
// Port-level checks on the working register set
`timescale 1ns/1ps
`default_nettype none

module cpu_working_register_set_chk
  import cpu_working_register_set_pkg::*;
(
  input wire logic        clk, rst, clk_en, mem_ref_valid, mem_ref_write, mem_ref_hit,
  input wire logic        panel_wr, carry_link_flag, overflow_flag, alu_flag_update,
  input wire logic        alu_carry_out, alu_overflow, int_serviced, parity_error,
  input wire logic        interrupt_system_enable, pc_step, pc_load,
  input wire flag_op_e    carry_op,
  input wire rot_op_e     rot_op,
  input wire addr_t       mem_ref_addr, program_counter,
  input wire word_t       mem_ref_wdata, mem_ref_rdata, first_accumulator, second_accumulator,
  input wire logic [5:0]  int_select_code, last_interrupt_code,
  input wire logic [23:0] parity_phys_addr, parity_fault_address
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_mem_first_read: assert property (clk_en && mem_ref_valid && !mem_ref_write
    && mem_ref_addr == 15'h0000 |=> mem_ref_hit && mem_ref_rdata == $past(first_accumulator))
    else $error("location zero read wrong");
  a_mem_second_write: assert property (clk_en && mem_ref_valid && mem_ref_write
    && mem_ref_addr == 15'h0001 && !panel_wr |=> second_accumulator == $past(mem_ref_wdata))
    else $error("location one write lost");
  a_carry_event_set: assert property (clk_en && alu_flag_update && alu_carry_out
    && !panel_wr && rot_op == ROT_NONE |=> carry_link_flag)
    else $error("carry did not set extend");
  a_carry_stays_set: assert property (carry_link_flag && carry_op == FLAG_HOLD
    && rot_op == ROT_NONE && !panel_wr |=> carry_link_flag)
    else $error("extend dropped without clear");
  a_ovf_event_set: assert property (clk_en && alu_flag_update && alu_overflow
    && !panel_wr |=> overflow_flag)
    else $error("overflow not flagged");
  a_int_code_load: assert property (clk_en && int_serviced
    |=> last_interrupt_code == $past(int_select_code))
    else $error("select code not captured");
  a_int_code_hold: assert property (!int_serviced |=> $stable(last_interrupt_code))
    else $error("select code changed");
  a_parity_load: assert property (clk_en && parity_error
    |=> parity_fault_address == $past(parity_phys_addr))
    else $error("parity address not captured");
  a_reset_int_off: assert property ($fell(rst) |-> !interrupt_system_enable)
    else $error("interrupt enable not cleared");
  a_pc_step_wrap: assert property (clk_en && pc_step && !pc_load && !panel_wr
    |=> program_counter == $past(program_counter) + 15'h0001)
    else $error("program counter step wrong");
endmodule // cpu_working_register_set_chk

bind cpu_working_register_set cpu_working_register_set_chk chk (.*);

`default_nettype wire

// ==== dp_model.sv ====
// Execution datapath model driving the register set's datapath side
`timescale 1ns/1ps
`default_nettype none

module dp_model
  import cpu_working_register_set_pkg::*;
(
  input  wire logic clk,
  output logic      acc_first_wr, acc_second_wr, alu_carry_out, alu_overflow, alu_flag_update,
  output logic      rot_use_link, rot_second, mem_ref_valid, mem_ref_write,
  output word_t     acc_result, mem_ref_wdata,
  output addr_t     mem_ref_addr,
  output flag_op_e  carry_op, ovf_op,
  output rot_op_e   rot_op
);
  task automatic idle();
    {acc_first_wr, acc_second_wr, alu_carry_out, alu_overflow, alu_flag_update} = '0;
    {rot_use_link, rot_second, mem_ref_valid, mem_ref_write} = '0;
    carry_op = FLAG_HOLD;
    ovf_op = FLAG_HOLD;
    rot_op = ROT_NONE;
    // Released lines flip so a stale value never looks valid
    acc_result = ~acc_result;
    mem_ref_wdata = ~mem_ref_wdata;
    mem_ref_addr = ~mem_ref_addr;
  endtask

  task automatic done();
    @(negedge clk);
    idle();
  endtask

  // Add result with its carry and overflow
  task automatic alu(input logic second, input word_t r, input logic c, ov);
    @(negedge clk);
    acc_second_wr = second;
    acc_first_wr = !second;
    acc_result = r;
    alu_flag_update = 1'b1;
    alu_carry_out = c;
    alu_overflow = ov;
    done();
  endtask

  task automatic flag(input flag_op_e c, ov);
    @(negedge clk);
    carry_op = c;
    ovf_op = ov;
    done();
  endtask

  // Rotate, optionally through the extend link
  task automatic rot(input rot_op_e r, input logic link, second);
    @(negedge clk);
    rot_op = r;
    rot_use_link = link;
    rot_second = second;
    done();
  endtask

  // Memory reference to any location; only zero and one hit the accumulators
  task automatic mem(input logic wr, input addr_t ad, input word_t d);
    @(negedge clk);
    mem_ref_valid = 1'b1;
    mem_ref_write = wr;
    mem_ref_addr = ad;
    mem_ref_wdata = d;
    done();
  endtask

  initial
  begin
    acc_result = '0;
    mem_ref_wdata = '0;
    mem_ref_addr = '0;
    idle();
  end
endmodule // dp_model

`default_nettype wire

// ==== cpu_working_register_set_tb.sv ====
// Self-checking testbench for the working register set
`timescale 1ns/1ps
`default_nettype none

module cpu_working_register_set_tb;
  import cpu_working_register_set_pkg::*;
  logic clk, rst, clk_en, pc_load, pc_step, int_serviced, int_enable_set, int_enable_clear;
  logic violation_detect, parity_error, index_first_wr, index_second_wr, map_word_wr;
  logic store_interrupt_map_instr, panel_rd, panel_wr, panel_rvalid, mem_ref_hit;
  logic acc_first_wr, acc_second_wr, alu_carry_out, alu_overflow, alu_flag_update;
  logic rot_use_link, rot_second, mem_ref_valid, mem_ref_write;
  logic carry_link_flag, overflow_flag, interrupt_system_enable;
  logic [5:0]  int_select_code, last_interrupt_code;
  logic [23:0] parity_phys_addr, parity_fault_address;
  logic [3:0]  panel_sel;
  addr_t       pc_value, fetch_addr, mem_ref_addr, program_counter, violation_address;
  word_t       acc_result, mem_ref_wdata, index_wdata, map_word_wdata, panel_wdata;
  word_t       first_accumulator, second_accumulator, index_reg_first, index_reg_second;
  word_t       working_map_word, mem_ref_rdata, int_map_rdata, panel_rdata;
  flag_op_e    carry_op, ovf_op;
  rot_op_e     rot_op;
  int          failures, cmp_count, cycles;

  cpu_working_register_set uut (.*);
  dp_model dp (.*);

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      finish_test();
    end
  end

  task automatic chk(input logic [23:0] g, e);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic pwr(input logic [3:0] s, input word_t d);
    @(negedge clk);
    {panel_wr, panel_sel, panel_wdata} = {1'b1, s, d};
    @(negedge clk);
    panel_wr = 1'b0;
    panel_wdata = ~panel_wdata;
  endtask

  task automatic prd(input logic [3:0] s, input logic [23:0] e);
    @(negedge clk);
    {panel_rd, panel_sel} = {1'b1, s};
    @(negedge clk);
    panel_rd = 1'b0;
    chk(panel_rvalid, 1'b1);
    chk(panel_rdata, e);
  endtask

  task automatic strobe(input logic [5:0] c, input addr_t v, input logic [23:0] pa);
    // Caller stands on a falling edge, so a map write can share the cycle
    {int_serviced, violation_detect, parity_error} = 3'b111;
    {int_select_code, fetch_addr, parity_phys_addr} = {c, v, pa};
    @(negedge clk);
    {int_serviced, violation_detect, parity_error, map_word_wr} = 4'h0;
  endtask

  task automatic t_acc();
    pwr(4'h0, 16'h1234);
    pwr(4'h1, 16'hbeef);
    prd(4'h0, 16'h1234);
    prd(4'h1, 16'hbeef);
    dp.mem(1'b0, 15'h0000, 16'h0000);
    chk(mem_ref_hit, 1'b1);
    chk(mem_ref_rdata, 16'h1234);
    dp.mem(1'b1, 15'h0001, 16'h5a5a);
    dp.mem(1'b0, 15'h0001, 16'h0000);
    chk(mem_ref_rdata, 16'h5a5a);
    dp.mem(1'b0, 15'h0002, 16'h0000);
    chk(mem_ref_hit, 1'b0);
    dp.alu(1'b0, 16'hffff, 1'b0, 1'b0);
    chk(first_accumulator, 16'hffff);
    chk(second_accumulator, 16'h5a5a);
    $display("t_acc done");
  endtask

  task automatic t_flags();
    dp.flag(FLAG_CLEAR, FLAG_CLEAR);
    dp.alu(1'b1, 16'h0000, 1'b1, 1'b0);
    chk(carry_link_flag, 1'b1);
    dp.alu(1'b1, 16'h0001, 1'b0, 1'b0);
    chk(carry_link_flag, 1'b1);
    dp.flag(FLAG_CLEAR, FLAG_HOLD);
    chk(carry_link_flag, 1'b0);
    dp.flag(FLAG_INVERT, FLAG_SET);
    chk({carry_link_flag, overflow_flag}, 2'b11);
    dp.flag(FLAG_SET, FLAG_INVERT);
    chk({carry_link_flag, overflow_flag}, 2'b11);
    dp.flag(FLAG_HOLD, FLAG_CLEAR);
    chk(overflow_flag, 1'b0);
    dp.alu(1'b0, 16'h8000, 1'b0, 1'b1);
    chk(overflow_flag, 1'b1);
    prd(4'h3, 1'b1);
    prd(4'h4, 1'b1);
    $display("t_flags done");
  endtask

  task automatic t_rot();
    pwr(4'h0, 16'h8001);
    dp.flag(FLAG_CLEAR, FLAG_HOLD);
    dp.rot(ROT_LEFT, 1'b1, 1'b0);
    chk({carry_link_flag, first_accumulator}, {1'b1, 16'h0002});
    dp.rot(ROT_RIGHT, 1'b1, 1'b0);
    chk({carry_link_flag, first_accumulator}, {1'b0, 16'h8001});
    pwr(4'h1, 16'h0001);
    dp.rot(ROT_RIGHT, 1'b0, 1'b1);
    chk({carry_link_flag, second_accumulator}, {1'b0, 16'h8000});
    $display("t_rot done");
  endtask

  task automatic t_capture();
    pwr(4'hc, 16'h3c3c);
    @(negedge clk);
    {map_word_wr, map_word_wdata} = {1'b1, 16'h7777};
    strobe(6'h2a, 15'h4567, 24'habcdef);
    chk(last_interrupt_code, 6'h2a);
    chk(violation_address, 15'h4567);
    chk(working_map_word, 16'h7777);
    prd(4'h7, 16'hcdef);
    prd(4'h8, 8'hab);
    @(negedge clk);
    store_interrupt_map_instr = 1'b1;
    @(negedge clk);
    store_interrupt_map_instr = 1'b0;
    chk(int_map_rdata, 16'h3c3c);
    prd(4'hd, 16'h0000);
    pwr(4'h5, 16'h0011);
    prd(4'h5, 6'h2a);
    strobe(6'h05, 15'h0100, 24'h000123);
    chk(parity_fault_address, 24'h000123);
    chk(last_interrupt_code, 6'h05);
    $display("t_capture done");
  endtask

  task automatic t_misc();
    @(negedge clk);
    {pc_load, pc_step, pc_value} = {2'b11, 15'h7ffe};
    @(negedge clk);
    pc_load = 1'b0;
    chk(program_counter, 15'h7ffe);
    repeat (2) @(negedge clk);
    pc_step = 1'b0;
    chk(program_counter, 15'h0000);
    @(negedge clk);
    {index_first_wr, index_wdata} = {1'b1, 16'h1111};
    @(negedge clk);
    {index_first_wr, index_second_wr, index_wdata} = {2'b01, 16'h2222};
    @(negedge clk);
    index_second_wr = 1'b0;
    chk({index_reg_first, index_reg_second}, {16'h1111, 16'h2222});
    @(negedge clk);
    int_enable_set = 1'b1;
    @(negedge clk);
    {int_enable_set, int_enable_clear, clk_en} = 3'b010;
    chk(interrupt_system_enable, 1'b1);
    @(negedge clk);
    clk_en = 1'b1;
    chk(interrupt_system_enable, 1'b1);
    @(negedge clk);
    int_enable_clear = 1'b0;
    chk(interrupt_system_enable, 1'b0);
    pwr(4'hf, 16'hffff);
    prd(4'hf, 16'h0000);
    pwr(4'h9, 16'h0001);
    prd(4'h9, 1'b1);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk(interrupt_system_enable, 1'b0);
    $display("t_misc done");
  endtask

  task automatic finish_test();
    $display("comparisons=%0d mismatches=%0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    {rst, clk_en} = 2'b11;
    {pc_load, pc_step, int_serviced, int_enable_set, int_enable_clear} = '0;
    {violation_detect, parity_error, index_first_wr, index_second_wr, map_word_wr} = '0;
    {store_interrupt_map_instr, panel_rd, panel_wr, int_select_code, panel_sel} = '0;
    {pc_value, fetch_addr, parity_phys_addr} = '0;
    {index_wdata, map_word_wdata, panel_wdata} = '0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t_acc();
    t_flags();
    t_rot();
    t_capture();
    t_misc();
    finish_test();
  end
endmodule // cpu_working_register_set_tb

`default_nettype wire
